// file: bench/mip_host_model.sv
// Host chipset model: runs phases, strobes and request acknowledges on the port
`timescale 1ns/10ps
module mip_host_model (
  input  wire logic        link_clk,
  input  wire logic [15:0] mad,
  input  wire logic        claim_n,
  input  wire logic        rdy,
  output logic             ale,
  output logic             cmd_n,
  output logic [15:0]      h_val,
  output logic             h_oe
);
  // ---------------------------------------------------------------
  // Idle levels: strobes inactive, bus floated
  // ---------------------------------------------------------------
  initial
  begin
    ale = 1'b0;
    cmd_n = 1'b1;
    h_val = 16'h0000;
    h_oe = 1'b0;
  end

  // One full cycle; a miss ends after the claim edge
  task automatic cycle(input logic [15:0] p1, input logic [15:0] p2, input logic [15:0] wd,
                       output logic claimed, output logic [15:0] rd);
    int n;
    n = 0;
    rd = 16'h0000;
    @(negedge link_clk);
    #1 h_oe = 1'b1;
    h_val = p1;
    @(negedge link_clk);
    #1 h_val = p2;
    ale = 1'b1;
    @(posedge link_clk);
    claimed = (claim_n === 1'b0);
    #1 claimed = claimed && (claim_n === 1'b0);
    ale = 1'b0;
    h_oe = claimed & p2[0];
    h_val = wd;
    if (claimed)
    begin
      @(posedge link_clk);
      #1 cmd_n = 1'b0;
      do
      begin
        @(posedge link_clk);
        n++;
      end
      while (rdy !== 1'b1 && n < 60);
      rd = mad;
      if (!p2[2])
        @(posedge link_clk);
      #1 cmd_n = 1'b1;
      h_oe = 1'b0;
      @(posedge link_clk);
    end
  endtask : cycle

  // Waits for a request level with the latch strobe low, then acknowledges it
  task automatic ack_req(output logic got);
    int n;
    n = 0;
    got = 1'b0;
    while (!got && n < 80)
    begin
      @(posedge link_clk);
      got = (claim_n === 1'b0) && !ale;
      n++;
    end
    #1 cmd_n = !got;
    @(posedge link_clk);
    #1 cmd_n = 1'b1;
  endtask : ack_req
endmodule : mip_host_model

// file: bench/mip_periph_tb_top.sv
// Self-checking testbench for the multiplexed ISA peripheral port
`timescale 1ns/10ps
module mip_periph_tb_top;
  logic sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, bus_rst = 1'b1, cyc_done = 1'b0;
  logic irq_req = 1'b0, stop_mode = 1'b0, wake_req = 1'b0, got;
  logic ale, cmd_n, h_oe, mad_oe, clm_oe, clm_out, wake_oe, rdy_out, rdy_oe, cyc_valid, irq_ack;
  logic [15:0] h_val, mad_out, rd;
  logic [15:0] rd_data = 16'h5A3C;
  mip_pkg::mip_cycle_t cyc;
  int err_total = 0, check_count = 0, ticks = 0, n;
  // Released bus shows the inverse of its last value; shared lines are pulled up
  wire [15:0] mad = mad_oe ? mad_out : (h_oe ? h_val : ~h_val);
  wire claim_n = (clm_oe | wake_oe) ? 1'b0 : 1'b1;
  wire rdy = rdy_oe ? rdy_out : 1'b1;
  always #4 sys_clk = ~sys_clk;
  always #15 link_clk = ~link_clk;
  // Core answers every cycle one clock later
  always @(negedge sys_clk) cyc_done <= cyc_valid;

  mip_periph DUT (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .bus_rst(bus_rst), .ale(ale),
    .cmd_n(cmd_n), .mad_in(mad), .muxed_addr_data_bus_out(mad_out), .muxed_addr_data_bus_oe(mad_oe),
    .claim_or_request_n_out(clm_out), .claim_or_request_n_oe(clm_oe), .wake_claim_n_oe(wake_oe),
    .ready_out(rdy_out), .ready_oe(rdy_oe), .cyc_valid(cyc_valid), .cyc(cyc), .cyc_done(cyc_done),
    .rd_data(rd_data), .irq_req(irq_req), .irq_ack(irq_ack), .stop_mode(stop_mode), .wake_req(wake_req));
  mip_host_model host (.link_clk(link_clk), .mad(mad), .claim_n(claim_n), .rdy(rdy), .ale(ale),
    .cmd_n(cmd_n), .h_val(h_val), .h_oe(h_oe));

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // Hang guard, far above the few hundred clocks the run needs
  always @(posedge sys_clk)
  begin
    ticks++;
    if (ticks == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  // Released ready only rises on a falling link edge
  always @(posedge rdy_out) if (rdy_oe) chk("ready edge", link_clk, 0);

  initial
  begin
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge link_clk);
    #1;
    chk("reset drivers", {mad_oe, clm_oe, rdy_oe}, 0);
    bus_rst = 1'b0;
    host.cycle(16'h00D5, 16'hA9ED, 16'h1234, got, rd);
    chk("fast write claim", got, 1);
    chk("claim level", clm_out, 0);
    chk("fast write cycle", cyc, {4'b0101, 24'h00D6A7, 16'h1234});
    host.cycle(16'h00D5, 16'h04C0, 16'h0000, got, rd);
    chk("slow read data", rd, 16'h5A3C);
    chk("slow read cycle", cyc[43:16], {4'b0000, 24'h00D413});
    host.cycle(16'hC302, 16'h3A45, 16'hBEEF, got, rd);
    chk("io write cycle", cyc, {4'b1100, 24'h00030D, 16'hBEEF});
    host.cycle(16'h00D4, 16'h04C0, 16'h0000, got, rd);
    chk("dma word ignored", got, 0);
    host.cycle(16'h0105, 16'h04C0, 16'h0000, got, rd);
    chk("miss ignored", got, 0);
    @(negedge sys_clk) irq_req = 1'b1;
    host.ack_req(got);
    chk("request seen", got, 1);
    n = 0;
    while (irq_ack !== 1'b1 && n < 60)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("request ack", irq_ack, 1);
    irq_req = 1'b0;
    @(negedge sys_clk);
    stop_mode = 1'b1;
    wake_req = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("wake pull", wake_oe, 1);
    end_of_test();
  end
endmodule : mip_periph_tb_top

// file: hw/mip_periph.sv
// Peripheral end of the multiplexed ISA port: decode, claim, ready and core handshake
`timescale 1ns/10ps
// Function
// [RL1] Memory phase one: bit0 high, bit1 low.
// [RL2] Bit1 low for memory; distinguishes io/dma.
// [RL3] Phase two: write, byte-high, fast bits.
// [RL4] Unused phase-two positions repeat; never decoded.
// [RL5] Io phase one: bit0 low, bit1 high.
// [RL6] Capture phase one on rising clock.
// [RL7] Owner claims, captures phase two at strobe.
// [RL8] Claim seen low with strobe high.
// [RL9] Host drops strobe on claim edge.
// [RL10] Host floats bus for read data.
// [RL11] Host drives write data in data phase.
// [RL12] Host asserts command strobe on rising edge.
// [RL13] Fast bit latched; ready may extend cycle.
// [RL14] Fast cycle: release ready on falling edge.
// [RL15] Host ends fast command when ready high.
// [RL16] Slow cycle: hold ready low, raise later.
// [RL17] Host ends slow command one edge later.
// [RL18] Strobe low: claim line requests, command acknowledges.
// [RL19] Stop-clock mode: pull line to restart.
// [RL20] Host captures command at strobe fall.
// [RL21] Bus reset floats drivers, clears everything. Wake pull-down and core side clear only on rst.

module mip_periph (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                link_clk,
  input  wire logic                bus_rst,
  input  wire logic                ale,
  input  wire logic                cmd_n,
  input  wire logic [15:0]         mad_in,
  output logic      [15:0]         muxed_addr_data_bus_out,
  output logic                     muxed_addr_data_bus_oe,
  output logic                     claim_or_request_n_out,
  output logic                     claim_or_request_n_oe,
  output logic                     wake_claim_n_oe,
  output logic                     ready_out,
  output logic                     ready_oe,
  output logic                     cyc_valid,
  output mip_pkg::mip_cycle_t      cyc,
  input  wire logic                cyc_done,
  input  wire logic [15:0]         rd_data,
  input  wire logic                irq_req,
  output logic                     irq_ack,
  input  wire logic                stop_mode,
  input  wire logic                wake_req
);

  // ---------------------------------------------------------------------------
  // State and decode
  // ---------------------------------------------------------------------------
  mip_pkg::mip_lnk_t lnk_q;        // Link rising-edge state
  mip_pkg::mip_lnk_t lnk_d;        // Its next value
  mip_pkg::mip_neg_t neg_q;        // Link falling-edge pin drivers
  mip_pkg::mip_neg_t neg_d;        // Its next value
  mip_pkg::mip_sys_t sys_q;        // Core-side state
  mip_pkg::mip_sys_t sys_d;        // Its next value
  logic              p1_mem_hit;   // Phase 1 word is a memory hit
  logic              p1_io_hit;    // Phase 1 word is an io hit
  logic [13:0]       p1_io_addr;   // Io phase 1 address, A15..A2
  logic              req_pend;     // Request pending and allowed onto the line

  // ---------------------------------------------------------------------------
  // Phase 1 decode
  // ---------------------------------------------------------------------------
  // Only the cycle-type bits and address fields are looked at; positions that
  // merely repeat an earlier phase are never trusted.
  assign p1_io_addr = {mad_in[mip_pkg::IO_P1_HI_LSB +: 6], mad_in[mip_pkg::IO_P1_LO_LSB +: 8]};  // see [RL5]

  // Memory needs type bit high and io/dma bit low
  assign p1_mem_hit = mad_in[mip_pkg::P1_MIO_BIT] & ~mad_in[mip_pkg::P1_ID_BIT]      // see [RL1] see [RL2]
                    & ((mad_in[mip_pkg::MEM_P1_LSB +: 14] & mip_pkg::MEM_HIT_MASK) == mip_pkg::MEM_HIT_BASE);

  // Io needs type bit low and io/dma bit high; dma encodings are not decoded
  assign p1_io_hit  = ~mad_in[mip_pkg::P1_MIO_BIT] & mad_in[mip_pkg::P1_ID_BIT]      // see [RL2] see [RL5]
                    & ((p1_io_addr & mip_pkg::IO_HIT_MASK) == mip_pkg::IO_HIT_BASE);

  // Request may go out only while no cycle is running and the strobe is low
  assign req_pend   = (lnk_q.state == mip_pkg::MIP_L_IDLE) & lnk_q.irq_s2 & ~lnk_q.irq_done & ~ale;

  // ---------------------------------------------------------------------------
  // Link sequencer, rising edge of the link clock
  // ---------------------------------------------------------------------------
  always_comb
  begin
    lnk_d          = lnk_q;
    // Answer and request levels cross in by two flip-flops each
    lnk_d.ack_s1   = sys_q.ack_tgl;
    lnk_d.ack_s2   = lnk_q.ack_s1;
    lnk_d.ack_prev = lnk_q.ack_s2;
    lnk_d.irq_s1   = sys_q.irq_lvl;
    lnk_d.irq_s2   = lnk_q.irq_s1;
    case (lnk_q.state)
      mip_pkg::MIP_L_IDLE:
      begin
        // Every idle edge may be a phase 1 word
        if (p1_mem_hit | p1_io_hit)
        begin
          lnk_d.state = mip_pkg::MIP_L_ADDR;                                         // see [RL6]
          lnk_d.is_io = p1_io_hit;
          lnk_d.hi    = p1_io_hit ? p1_io_addr : mad_in[mip_pkg::MEM_P1_LSB +: 14];  // see [RL6]
        end
      end
      mip_pkg::MIP_L_ADDR:
      begin
        // Strobe high on this edge: host sees our claim, phase 2 is on the bus
        if (ale)
        begin
          lnk_d.state     = mip_pkg::MIP_L_DATA;                                     // see [RL7]
          lnk_d.cyc.is_io = lnk_q.is_io;
          lnk_d.cyc.write = mad_in[mip_pkg::P2_WR_BIT];                              // see [RL3]
          lnk_d.cyc.bhe_n = mad_in[mip_pkg::P2_BHE_BIT];                             // see [RL3]
          // Io cycles carry no fast option; treat them as slow
          lnk_d.cyc.fast  = ~lnk_q.is_io & mad_in[mip_pkg::P2_FAST_BIT];             // see [RL13]
          if (lnk_q.is_io)
            lnk_d.cyc.addr = {mip_pkg::IO_ADDR_PAD, lnk_q.hi, mad_in[mip_pkg::IO_P2_LSB +: 2]};
          else
            lnk_d.cyc.addr = {lnk_q.hi, mad_in[mip_pkg::MEM_P2_LSB +: 10]};          // see [RL3] see [RL4]
        end
        // No strobe came; this edge is another phase 1 word
        else if (p1_mem_hit | p1_io_hit)
        begin
          lnk_d.is_io = p1_io_hit;
          lnk_d.hi    = p1_io_hit ? p1_io_addr : mad_in[mip_pkg::MEM_P1_LSB +: 14];
        end
        else
        begin
          lnk_d.state = mip_pkg::MIP_L_IDLE;
        end
      end
      mip_pkg::MIP_L_DATA:
      begin
        // First edge with the command low: write data is valid now
        if (~cmd_n)
        begin
          lnk_d.cyc.wdata = mad_in;
          lnk_d.req_tgl   = ~lnk_q.req_tgl;
          lnk_d.ack_seen  = 1'b0;
          lnk_d.state     = mip_pkg::MIP_L_WAIT;
        end
      end
      mip_pkg::MIP_L_WAIT:
      begin
        // Core answered; its read data has been still since the toggle flipped
        if (lnk_q.ack_s2 != lnk_q.ack_prev)
        begin
          lnk_d.ack_seen = 1'b1;
          lnk_d.rdata    = sys_q.rdata;
        end
        // Host ended the command after seeing ready high
        else if (lnk_q.ack_seen & cmd_n)
        begin
          lnk_d.state = mip_pkg::MIP_L_IDLE;                                         // see [RL15] see [RL17]
        end
      end
      default:
      begin
        lnk_d.state = mip_pkg::MIP_L_IDLE;
      end
    endcase
    // Request handshake: command low with strobe low acknowledges our request
    if (lnk_q.irq_done & ~lnk_q.irq_s2)
      lnk_d.irq_done = 1'b0;
    if (neg_q.req_drive & (lnk_q.state == mip_pkg::MIP_L_IDLE) & ~cmd_n & ~ale)
    begin
      lnk_d.irq_done = 1'b1;                                                         // see [RL18]
      lnk_d.ia_tgl   = ~lnk_q.ia_tgl;
    end
    // Bus reset returns to idle decoding with nothing pending
    if (bus_rst)
      lnk_d = '0;                                                                    // see [RL21]
  end

  // Link rising-edge register
  always_ff @(posedge link_clk)
  begin
    lnk_q <= lnk_d;
  end

  // ---------------------------------------------------------------------------
  // Pin drivers, falling edge of the link clock
  // ---------------------------------------------------------------------------
  // Driving on the falling edge puts claim and ready in place half a clock
  // before the host samples them; the cost is a half-cycle timing path.
  always_comb
  begin
    neg_d           = neg_q;
    // Claim from the falling edge where the latch strobe rises; request when idle
    neg_d.claim_oe  = (lnk_q.state == mip_pkg::MIP_L_ADDR) | req_pend;     // see [RL7] see [RL8] see [RL18]
    neg_d.req_drive = req_pend;                                                      // see [RL18]
    // Ready pulled low as soon as the command is seen, before the host samples it
    neg_d.rdy_oe    = ((lnk_q.state == mip_pkg::MIP_L_DATA) & ~cmd_n)
                    | (lnk_q.state == mip_pkg::MIP_L_WAIT);                          // see [RL13] see [RL16]
    // Released high on a falling edge once the core has answered
    neg_d.rdy_out   = (lnk_q.state == mip_pkg::MIP_L_WAIT) & lnk_q.ack_seen;        // see [RL14] see [RL16]
    // Read data only while the host has floated its drivers
    neg_d.mad_oe    = (lnk_q.state == mip_pkg::MIP_L_WAIT) & lnk_q.ack_seen
                    & ~lnk_q.cyc.write;                                              // see [RL10]
    neg_d.mad_out   = lnk_q.rdata;
    // Every driver except the wake pull-down floats during bus reset
    if (bus_rst)
      neg_d = '0;                                                                    // see [RL21]
  end

  // Link falling-edge register
  always_ff @(negedge link_clk)
  begin
    neg_q <= neg_d;
  end

  // ---------------------------------------------------------------------------
  // Core side, system clock
  // ---------------------------------------------------------------------------
  always_comb
  begin
    sys_d           = sys_q;
    // Cycle event: toggle crosses, cycle word is held still by the link
    sys_d.req_s1    = lnk_q.req_tgl;
    sys_d.req_s2    = sys_q.req_s1;
    sys_d.req_prev  = sys_q.req_s2;
    sys_d.cyc_valid = sys_q.req_s2 != sys_q.req_prev;
    if (sys_q.req_s2 != sys_q.req_prev)
      sys_d.cyc = lnk_q.cyc;
    // Answer: data is stored on the same edge that the toggle flips
    if (cyc_done)
    begin
      sys_d.rdata   = rd_data;
      sys_d.ack_tgl = ~sys_q.ack_tgl;
    end
    // Request level and its acknowledge event
    sys_d.irq_lvl   = irq_req;
    sys_d.ia_s1     = lnk_q.ia_tgl;
    sys_d.ia_s2     = sys_q.ia_s1;
    sys_d.ia_prev   = sys_q.ia_s2;
    sys_d.irq_ack   = sys_q.ia_s2 != sys_q.ia_prev;
    // Restart request does not need the stopped link clock
    sys_d.wake_oe   = stop_mode & wake_req;                                          // see [RL19]
    if (rst)
      sys_d = '0;
  end

  // Core-side register
  always_ff @(posedge sys_clk)
  begin
    sys_q <= sys_d;
  end

  // ---------------------------------------------------------------------------
  // Outputs, all straight from flip-flops except the claim level, which is tied low
  // ---------------------------------------------------------------------------
  assign muxed_addr_data_bus_out = neg_q.mad_out;
  assign muxed_addr_data_bus_oe  = neg_q.mad_oe;
  assign claim_or_request_n_out  = 1'b0 & neg_q.claim_oe;  // Line only ever pulled low
  assign claim_or_request_n_oe   = neg_q.claim_oe;
  assign wake_claim_n_oe         = sys_q.wake_oe;
  assign ready_out               = neg_q.rdy_out;
  assign ready_oe                = neg_q.rdy_oe;
  assign cyc_valid               = sys_q.cyc_valid;
  assign cyc                     = sys_q.cyc;
  assign irq_ack                 = sys_q.irq_ack;

  // ---------------------------------------------------------------------------
  // Assertions, link clock; the wake check runs on the core clock
  // ---------------------------------------------------------------------------
  property p_p1_capture;
    @(posedge link_clk) disable iff (bus_rst)
    (lnk_q.state == mip_pkg::MIP_L_IDLE) && !(p1_mem_hit || p1_io_hit) |=> lnk_q.state != mip_pkg::MIP_L_ADDR;
  endproperty
  a_p1_capture: assert property (p_p1_capture) else $error("Address state without a phase 1 hit"); // see [RL6]

  property p_p2_capture;
    @(posedge link_clk) disable iff (bus_rst)
    (lnk_q.state == mip_pkg::MIP_L_ADDR) && ale && !lnk_q.is_io
      |=> (lnk_q.state == mip_pkg::MIP_L_DATA) && (lnk_q.cyc.addr[9:0] == $past(mad_in[15:6]))
          && (lnk_q.cyc.write == $past(mad_in[0]));
  endproperty
  a_p2_capture: assert property (p_p2_capture) else $error("Phase 2 not captured at the strobe"); // see [RL7]

  property p_claim_out;
    @(posedge link_clk) disable iff (bus_rst)
    (lnk_q.state == mip_pkg::MIP_L_ADDR) |-> neg_q.claim_oe;
  endproperty
  a_claim_out: assert property (p_claim_out) else $error("Claim missing while address state"); // see [RL8]

  property p_fast_latch;
    @(posedge link_clk) disable iff (bus_rst)
    (lnk_q.state == mip_pkg::MIP_L_ADDR) && ale && !lnk_q.is_io |=> lnk_q.cyc.fast == $past(mad_in[2]);
  endproperty
  a_fast_latch: assert property (p_fast_latch) else $error("Fast timing bit not latched"); // see [RL13]

  property p_rdy_release;
    @(posedge link_clk) disable iff (bus_rst)
    (lnk_q.state == mip_pkg::MIP_L_WAIT) && lnk_q.ack_seen && !cmd_n |=> neg_q.rdy_oe && neg_q.rdy_out;
  endproperty
  a_rdy_release: assert property (p_rdy_release) else $error("Ready not released after answer"); // see [RL14]

  property p_rdy_hold;
    @(posedge link_clk) disable iff (bus_rst)
    (lnk_q.state == mip_pkg::MIP_L_WAIT) && !lnk_q.ack_seen |-> neg_q.rdy_oe && !neg_q.rdy_out;
  endproperty
  a_rdy_hold: assert property (p_rdy_hold) else $error("Ready not held low while waiting"); // see [RL16]

  property p_rd_drive;
    @(posedge link_clk) disable iff (bus_rst)
    neg_q.mad_oe |-> $past(lnk_q.state == mip_pkg::MIP_L_WAIT) && !$past(lnk_q.cyc.write);
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("Bus driven outside a read data phase"); // see [RL10]

  property p_req_line;
    @(posedge link_clk) disable iff (bus_rst)
    (lnk_q.state == mip_pkg::MIP_L_IDLE) && lnk_q.irq_s2 && !lnk_q.irq_done && !ale && cmd_n
      && !(p1_mem_hit || p1_io_hit)
      |=> neg_q.claim_oe && neg_q.req_drive;
  endproperty
  a_req_line: assert property (p_req_line) else $error("Pending request not shown on the line"); // see [RL18]

  property p_bus_reset;
    @(posedge link_clk)
    $past(bus_rst, 2) && $past(bus_rst) |-> (lnk_q.state == mip_pkg::MIP_L_IDLE)
      && !neg_q.claim_oe && !neg_q.rdy_oe && !neg_q.mad_oe;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("Drivers not floated in bus reset"); // see [RL21]

  // Data phase word taken on the first edge that sees the command low
  property p_wdata_capture;
    @(posedge link_clk) disable iff (bus_rst)
    (lnk_q.state == mip_pkg::MIP_L_DATA) && !cmd_n
      |=> (lnk_q.state == mip_pkg::MIP_L_WAIT) && (lnk_q.cyc.wdata == $past(mad_in));
  endproperty
  a_wdata_capture: assert property (p_wdata_capture) else $error("Write data not captured"); // see [RL11]

  // Wake pull-down runs on the core clock, since the link clock may be stopped
  property p_wake_pull;
    @(posedge sys_clk) disable iff (rst)
    stop_mode && wake_req |=> wake_claim_n_oe;
  endproperty
  a_wake_pull: assert property (p_wake_pull) else $error("Clock restart pull missing"); // see [RL19]

  c_fast_write: cover property (@(posedge link_clk) disable iff (bus_rst)
    (lnk_q.state == mip_pkg::MIP_L_WAIT) && lnk_q.cyc.fast && lnk_q.cyc.write ##1 lnk_q.ack_seen);
  c_slow_read:  cover property (@(posedge link_clk) disable iff (bus_rst)
    neg_q.mad_oe && !lnk_q.cyc.fast);
  c_req_ack:    cover property (@(posedge link_clk) disable iff (bus_rst)
    $rose(lnk_q.irq_done));
  c_io_cycle:   cover property (@(posedge link_clk) disable iff (bus_rst)
    (lnk_q.state == mip_pkg::MIP_L_WAIT) && lnk_q.cyc.is_io && lnk_q.ack_seen);
  c_wake:       cover property (@(posedge sys_clk) disable iff (rst)
    $rose(sys_q.wake_oe));

endmodule : mip_periph

// file: hw/mip_pkg.sv
// Shared constants and carrier types for the multiplexed ISA peripheral port
package mip_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry and bit positions of the multiplexed word
  // ---------------------------------------------------------------------------
  localparam int          MAD_W        = 16;     // Multiplexed bus width
  localparam int          P1_MIO_BIT   = 0;      // Phase 1: memory-not-io
  localparam int          P1_ID_BIT    = 1;      // Phase 1: io-not-dma
  localparam int          P2_WR_BIT    = 0;      // Phase 2: write-not-read
  localparam int          P2_BHE_BIT   = 1;      // Phase 2: byte-high enable, low active
  localparam int          P2_FAST_BIT  = 2;      // Phase 2: fast_timing_bit
  localparam int          MEM_P1_LSB   = 2;      // Phase 1 memory: A23..A10 on bits 15..2
  localparam int          MEM_P2_LSB   = 6;      // Phase 2 memory: A9..A0 on bits 15..6
  localparam int          IO_P1_LO_LSB = 8;      // Phase 1 io: A9..A2 on bits 15..8
  localparam int          IO_P1_HI_LSB = 2;      // Phase 1 io: A15..A10 on bits 7..2
  localparam int          IO_P2_LSB    = 6;      // Phase 2 io: A1..A0 on bits 7..6

  // ---------------------------------------------------------------------------
  // Decode windows (plain defaults, compared on the phase 1 address)
  // ---------------------------------------------------------------------------
  localparam logic [13:0] MEM_HIT_BASE = 14'h0034; // A23..A10 of the memory window
  localparam logic [13:0] MEM_HIT_MASK = 14'h3FFC; // 4 KiB memory window
  localparam logic [13:0] IO_HIT_BASE  = 14'h00C0; // A15..A2 of the io window
  localparam logic [13:0] IO_HIT_MASK  = 14'h3FFC; // 16 byte io window
  localparam logic [7:0]  IO_ADDR_PAD  = 8'h00;    // Upper io address bits

  // ---------------------------------------------------------------------------
  // Link-side cycle sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MIP_L_IDLE = 2'b00,   // Watching phase 1 words
    MIP_L_ADDR = 2'b01,   // Hit decoded, claim out, waiting for the latch strobe
    MIP_L_DATA = 2'b10,   // Claimed, waiting for the command strobe
    MIP_L_WAIT = 2'b11    // Cycle handed to the core, holding ready
  } mip_lstate_t;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        is_io;   // Io cycle rather than memory cycle
    logic        write;   // Write-not-read
    logic        bhe_n;   // Byte-high enable, low active
    logic        fast;    // Zero-wait timing requested
    logic [23:0] addr;    // Full byte address
    logic [15:0] wdata;   // Write data from the data phase
  } mip_cycle_t;

  typedef struct packed {
    mip_lstate_t state;   // Sequencer state
    logic        is_io;   // Phase 1 was an io hit
    logic [13:0] hi;      // Phase 1 address bits
    mip_cycle_t  cyc;     // Assembled cycle, held across the crossing
    logic        req_tgl; // Cycle event toward the core
    logic        ack_s1;  // Core answer synchroniser, first stage
    logic        ack_s2;  // Core answer synchroniser, second stage
    logic        ack_prev;// Edge history of the answer
    logic        ack_seen;// Core answered this cycle
    logic [15:0] rdata;   // Read data taken over from the core
    logic        irq_s1;  // Request level synchroniser, first stage
    logic        irq_s2;  // Request level synchroniser, second stage
    logic        irq_done;// Request acknowledged by the host
    logic        ia_tgl;  // Acknowledge event toward the core
  } mip_lnk_t;

  typedef struct packed {
    logic        claim_oe;  // Claim/request line pulled low
    logic        req_drive; // Low level is a request, not a claim
    logic        rdy_oe;    // Ready line driven
    logic        rdy_out;   // Ready level when driven
    logic        mad_oe;    // Read data driven on the bus
    logic [15:0] mad_out;   // Read data
  } mip_neg_t;

  typedef struct packed {
    logic        req_s1;    // Cycle event synchroniser, first stage
    logic        req_s2;    // Cycle event synchroniser, second stage
    logic        req_prev;  // Edge history
    logic        cyc_valid; // One-cycle cycle strobe to the core
    mip_cycle_t  cyc;       // Cycle presented to the core
    logic        ack_tgl;   // Answer event toward the link
    logic [15:0] rdata;     // Read data held for the link
    logic        irq_lvl;   // Registered request level
    logic        ia_s1;     // Acknowledge synchroniser, first stage
    logic        ia_s2;     // Acknowledge synchroniser, second stage
    logic        ia_prev;   // Edge history
    logic        irq_ack;   // One-cycle acknowledge pulse
    logic        wake_oe;   // Clock restart pull-down
  } mip_sys_t;

endpackage : mip_pkg
